/* File: dv/receiver_error_status_unit_tb.sv */
// Purpose: Self-checking bench for the error/status unit
// Assumes: Inputs driven on the falling edge, seed fixed
// Notes:   Reference toggles at half sys_clk with frames 256 cycles apart,
//          the same 128 edges per frame as 6.144 MHz against 48 kHz
`timescale 1ns/1ps
module receiver_error_status_unit_tb;
    import resu_pkg::*;
    logic          sys_clk, rstn, cs_n, rd_wr, top_address_in, rate_reference_clock;
    logic [1:0]    addr;
    logic [7:0]    data_in, data_out, q, d, n;
    logic          data_oe, error_pin, int_n, top_address_bit, locked, en, ref_run;
    resu_line_ev_t line_ev;
    resu_sync_t    sync_in;
    int            n_fail, tests_run, r;

    // ==========================================================
    // Clock and instances
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    always @(negedge sys_clk) begin
        if (ref_run) begin
            rate_reference_clock <= ~rate_reference_clock;
        end
    end

    resu_host host (.sys_clk(sys_clk), .data_out(data_out), .data_oe(data_oe), .cs_n(cs_n),
        .rd_wr(rd_wr), .addr(addr), .data_in(data_in));

    resu_top dut (.sys_clk(sys_clk), .rstn(rstn), .cs_n(cs_n), .rd_wr(rd_wr),
        .addr(addr), .top_address_in(top_address_in), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe),
        .rate_reference_clock(rate_reference_clock), .line_ev(line_ev),
        .sync_in(sync_in), .error_pin(error_pin), .int_n(int_n),
        .top_address_bit(top_address_bit), .locked(locked));

    // ==========================================================
    // Helpers
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] v);
        host.acc(1'b0, a, v, q);
        chk({7'h0, host.oe_seen}, 8'h00);
    endtask

    task automatic rd(input logic [1:0] a, input logic [7:0] m, input logic [7:0] e);
        host.acc(1'b1, a, 8'h00, q);
        chk({7'h0, host.oe_seen}, 8'h01);
        chk(q & m, e);
    endtask

    task automatic ev(input int k);
        @(negedge sys_clk);
        line_ev.validity = (k == 0);
        line_ev.parity = (k == 1);
        line_ev.coding = (k == 2);
        @(negedge sys_clk);
        line_ev = '0;
    endtask

    task automatic sp(input int k);
        @(negedge sys_clk);
        sync_in.frame_pre = (k == 0);
        sync_in.block_pre = (k == 1);
        sync_in.frame_slot = (k == 2);
        @(negedge sys_clk);
        {sync_in.frame_pre, sync_in.block_pre, sync_in.frame_slot} = 3'h0;
    endtask

    // Window wide enough to hold a whole pulse; the pulse may already be
    // low at the falling edge on which the event is withdrawn
    task automatic cnt_irq();
        n = 8'h00;
        repeat (24) begin
            if (int_n === 1'b0) n = n + 8'h01;
            @(negedge sys_clk);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge sys_clk);
        n_fail++;
        complete_run();
    end

    // ==========================================================
    // Tests
    initial begin
        rstn = 1'b0;
        line_ev = '0;
        sync_in = '0;
        top_address_in = 1'b0;
        rate_reference_clock = 1'b0;
        ref_run = 1'b0;
        n_fail = 0;
        tests_run = 0;
        r = $urandom(14);
        repeat (6) @(negedge sys_clk);
        rstn = 1'b1;
        chk({4'h0, error_pin, int_n, locked, top_address_bit}, 8'h04);
        rd(2'h1, 8'hff, 8'h08);
        rd(2'h1, 8'hff, 8'h08);
        $display("test reset done");

        sync_in.line_active = 1'b1;
        sync_in.rate_in_range = 1'b1;
        repeat (3) sp(0);
        sp(1);
        repeat (4) @(negedge sys_clk);
        chk({7'h0, locked}, 8'h01);
        rd(2'h1, 8'hff, 8'h08);
        rd(2'h1, 8'hff, 8'h00);
        $display("test lock done");

        wr(2'h2, 8'h20);
        for (int i = 0; i < 8; i++) begin
            d = 8'($urandom) & 8'h3f;
            wr(2'h1, d);
            rd(2'h1, 8'hff, d & ERR_EN_WMASK);
            wr(2'h0, d);
            rd(2'h0, 8'hff, d);
        end
        $display("test enables done");

        for (int i = 0; i < 3; i++) begin
            en = (i == 1) ? 1'b1 : 1'($urandom);
            wr(2'h2, 8'h20);
            wr(2'h1, 8'({7'h0, en}) << i);
            wr(2'h0, 8'h08);
            wr(2'h2, 8'h00);
            host.acc(1'b1, 2'h0, 8'h00, q);
            ev(i);
            cnt_irq();
            chk(n, en ? 8'h10 : 8'h00);
            chk({7'h0, error_pin}, {7'h0, en});
            rd(2'h1, 8'hff, 8'h01 << i);
            repeat (2) @(negedge sys_clk);
            chk({7'h0, error_pin}, 8'h00);
            rd(2'h0, 8'h08, 8'({en, 3'h0}));
        end
        $display("test errors done");

        wr(2'h2, 8'h20);
        wr(2'h1, 8'h02);
        wr(2'h0, 8'h00);
        ev(1);
        cnt_irq();
        chk(n, 8'h00);
        wr(2'h0, 8'h08);
        wr(2'h2, 8'h00);
        rd(2'h0, 8'h08, 8'h08);
        rd(2'h1, 8'hff, 8'h02);
        ev(1);
        cnt_irq();
        chk(n, 8'h10);
        ev(1);
        cnt_irq();
        chk(n, 8'h00);
        chk({7'h0, error_pin}, 8'h01);
        host.acc(1'b1, 2'h0, 8'h00, q);
        ev(1);
        cnt_irq();
        chk(n, 8'h10);
        rd(2'h1, 8'hff, 8'h02);
        // Parity event lands on the very edge that takes the clearing read
        fork
            host.acc(1'b1, 2'h1, 8'h00, q);
            ev(1);
        join
        rd(2'h1, 8'hff, 8'h02);
        $display("test interrupt once done");

        wr(2'h2, 8'h20);
        wr(2'h1, 8'h08);
        wr(2'h2, 8'h00);
        repeat (4) sp(2);
        repeat (3) @(negedge sys_clk);
        chk({7'h0, locked}, 8'h00);
        chk({7'h0, error_pin}, 8'h01);
        rd(2'h1, 8'hff, 8'h08);
        $display("test lock loss done");

        ref_run = 1'b1;
        repeat (3) sp(0);
        sp(1);
        repeat (3) @(negedge sys_clk);
        wr(2'h2, 8'h40);
        // One full window of 64 frames with the reference running throughout
        repeat (64) begin
            repeat (254) @(negedge sys_clk);
            sp(0);
        end
        repeat (2) @(negedge sys_clk);
        rd(2'h1, 8'he0, {RATE_48_N, 5'h00});
        ref_run = 1'b0;
        $display("test rate done");

        top_address_in = 1'b1;
        wr(2'h2, 8'h40);
        repeat (2) @(negedge sys_clk);
        chk({7'h0, top_address_bit}, 8'h00);
        wr(2'h2, 8'h00);
        repeat (2) @(negedge sys_clk);
        chk({7'h0, top_address_bit}, 8'h01);
        $display("test address done");
        complete_run();
    end
endmodule

/* File: dv/resu_host.sv */
// Purpose: Host model driving the byte-wide parallel port
// Assumes: One access per cs_n low, cs_n high at least one edge between
// Notes:   Released lines carry inverted values so stale data cannot match
`timescale 1ns/1ps
module resu_host (
    input  wire logic       sys_clk,
    input  wire logic [7:0] data_out,
    input  wire logic       data_oe,
    output logic            cs_n,
    output logic            rd_wr,
    output logic [1:0]      addr,
    output logic [7:0]      data_in
);
    // ==========================================================
    // Access task
    logic oe_seen;

    initial begin
        cs_n = 1'b1;
        rd_wr = 1'b1;
        addr = 2'h3;
        data_in = 8'h00;
    end

    // Request held across the taking edge, read data one cycle later
    task automatic acc(input logic rw, input logic [1:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        @(negedge sys_clk);
        cs_n = 1'b0;
        rd_wr = rw;
        addr = a;
        data_in = d;
        @(negedge sys_clk);
        oe_seen = data_oe;
        cs_n = 1'b1;
        addr = ~a;
        data_in = ~d;
        @(negedge sys_clk);
        q = data_out;
    endtask
endmodule

/* File: rtl/resu_int_pulse.sv */
// Purpose: Active-low interrupt pulse, a fixed number of serial clocks wide
// Assumes: Serial clock is sys_clk divided by SCLK_DIV
// Notes:   A request during a pulse merges into it
`timescale 1ns/1ps
module resu_int_pulse
    import resu_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic rstn,
    input  wire logic fire,
    output logic      int_n
);
    logic [1:0] div_reg;
    logic [2:0] sclk_cnt_reg;
    logic       busy_reg;
    logic       tick;

    assign tick = (div_reg == 2'(SCLK_DIV - 1));

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            div_reg <= 2'h0;
        end else if (!busy_reg) begin
            div_reg <= 2'h0;
        end else begin
            div_reg <= div_reg + 2'h1;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            busy_reg     <= 1'b0;
            sclk_cnt_reg <= 3'h0;
            int_n        <= 1'b1;
        end else if (!busy_reg) begin
            if (fire) begin
                busy_reg     <= 1'b1;
                sclk_cnt_reg <= 3'h0;
                int_n        <= 1'b0;
            end
        end else if (tick) begin
            if (sclk_cnt_reg == 3'(INT_PULSE_SCLKS - 1)) begin
                busy_reg <= 1'b0;
                int_n    <= 1'b1;
            end else begin
                sclk_cnt_reg <= sclk_cnt_reg + 3'h1;
            end
        end
    end
endmodule

/* File: rtl/resu_pkg.sv */
// Purpose: Shared constants and types for the receiver error/status unit
// Assumes: Byte-wide parallel port, recovered clock as sys_clk
// Notes:   Rate windows are counts of reference edges over 64 frames
package resu_pkg;

    // ==================================================================
    // Register map
    localparam logic [1:0] ADDR_STAT_LO    = 2'h0;
    localparam logic [1:0] ADDR_STAT_HI    = 2'h1;
    localparam logic [1:0] ADDR_CONTROL    = 2'h2;
    localparam int         BIT_ERROR_FLAG  = 3;
    localparam int         BIT_BANK_SEL    = 5;
    localparam int         BIT_RATE_EN     = 6;
    localparam int         BIT_VALIDITY    = 0;
    localparam int         BIT_PARITY      = 1;
    localparam int         BIT_CODING      = 2;
    localparam int         BIT_LOCK        = 3;
    localparam logic [7:0] ERR_EN_WMASK    = 8'hdf;
    localparam logic [7:0] RESET_BYTE      = 8'h00;

    // ==================================================================
    // Timing
    localparam int         SCLK_DIV        = 4;
    localparam int         INT_PULSE_SCLKS = 4;
    localparam int         LOCK_FRAMES     = 3;
    localparam int         LOSS_MISSES     = 4;
    localparam logic [5:0] WINDOW_LAST     = 6'h3f;

    // ==================================================================
    // Rate windows: reference edges counted over one third of a block
    localparam logic [13:0] R48_W_LO  = 14'd7864;
    localparam logic [13:0] R48_W_HI  = 14'd8520;
    localparam logic [13:0] R441_W_LO = 14'd8560;
    localparam logic [13:0] R441_W_HI = 14'd9274;
    localparam logic [13:0] R32_W_LO  = 14'd11796;
    localparam logic [13:0] R32_W_HI  = 14'd12780;
    localparam logic [13:0] R48_N_LO  = 14'd8189;
    localparam logic [13:0] R48_N_HI  = 14'd8195;
    localparam logic [13:0] R441_N_LO = 14'd8913;
    localparam logic [13:0] R441_N_HI = 14'd8920;
    localparam logic [13:0] R44_N_LO  = 14'd8922;
    localparam logic [13:0] R44_N_HI  = 14'd8929;
    localparam logic [13:0] R32_N_LO  = 14'd12283;
    localparam logic [13:0] R32_N_HI  = 14'd12292;

    localparam logic [2:0] RATE_NONE   = 3'h0;
    localparam logic [2:0] RATE_48_W   = 3'h1;
    localparam logic [2:0] RATE_441_W  = 3'h2;
    localparam logic [2:0] RATE_32_W   = 3'h3;
    localparam logic [2:0] RATE_48_N   = 3'h4;
    localparam logic [2:0] RATE_441_N  = 3'h5;
    localparam logic [2:0] RATE_44_N   = 3'h6;
    localparam logic [2:0] RATE_32_N   = 3'h7;

    typedef struct packed {
        logic validity;
        logic parity;
        logic coding;
    } resu_line_ev_t;

    typedef struct packed {
        logic frame_pre;
        logic block_pre;
        logic frame_slot;
        logic line_active;
        logic rate_in_range;
    } resu_sync_t;

endpackage

/* File: rtl/resu_top.sv */
// Purpose: Line error latches, error pin, first-level error flag, interrupt
//          enables, lock tracking and sample-rate meter
// Assumes: Parallel port pins and line events are synchronous to sys_clk
// Notes:   Access is taken on the first low cycle of cs_n
`timescale 1ns/1ps
module resu_top
    import resu_pkg::*;
(
    input  wire logic          sys_clk,
    input  wire logic          rstn,
    input  wire logic          cs_n,
    input  wire logic          rd_wr,
    input  wire logic [1:0]    addr,
    input  wire logic          top_address_in,
    input  wire logic [7:0]    data_in,
    output logic      [7:0]    data_out,
    output logic               data_oe,
    input  wire logic          rate_reference_clock,
    input  wire resu_line_ev_t line_ev,
    input  wire resu_sync_t    sync_in,
    output logic               error_pin,
    output logic               int_n,
    output logic               top_address_bit,
    output logic               locked
);
    // ==================================================================
    // Parallel port
    logic       cs_n_q;
    logic       access;
    logic       wr_acc;
    logic       rd_acc;
    logic [7:0] first_level_irq_enable;
    logic [7:0] line_error_enable;
    logic [7:0] control_one;
    logic [7:0] first_status_reg;
    logic [7:0] line_error_status;
    logic       bank_select;
    logic       rate_meter_enable;
    logic       clr_first;
    logic       clr_line;
    logic [7:0] rd_mux;

    assign access            = cs_n_q && !cs_n;
    assign wr_acc            = access && !rd_wr;
    assign rd_acc            = access && rd_wr;
    assign bank_select       = control_one[BIT_BANK_SEL];
    assign rate_meter_enable = control_one[BIT_RATE_EN];
    assign clr_first         = rd_acc && !bank_select && addr == ADDR_STAT_LO;
    assign clr_line          = rd_acc && !bank_select && addr == ADDR_STAT_HI;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cs_n_q <= 1'b1;
        end else begin
            cs_n_q <= cs_n;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            first_level_irq_enable <= RESET_BYTE;
            line_error_enable      <= RESET_BYTE;
            control_one            <= RESET_BYTE;
        end else if (wr_acc) begin
            unique case (addr)
                ADDR_STAT_LO: begin
                    if (bank_select) begin
                        first_level_irq_enable <= data_in;
                    end
                end
                ADDR_STAT_HI: begin
                    if (bank_select) begin
                        // Bit 5 has no storage and reads back as zero
                        line_error_enable <= data_in & ERR_EN_WMASK;
                    end
                end
                ADDR_CONTROL: control_one <= data_in;
                default: ;
            endcase
        end
    end

    always_comb begin
        rd_mux = RESET_BYTE;
        unique case (addr)
            ADDR_STAT_LO: rd_mux = bank_select ? first_level_irq_enable : first_status_reg;
            ADDR_STAT_HI: rd_mux = bank_select ? line_error_enable : line_error_status;
            ADDR_CONTROL: rd_mux = control_one;
            default:      rd_mux = RESET_BYTE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            data_out <= RESET_BYTE;
            data_oe  <= 1'b0;
        end else begin
            if (rd_acc) begin
                data_out <= rd_mux;
            end
            data_oe <= !cs_n && rd_wr;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            top_address_bit <= 1'b0;
        end else begin
            // Reference clock shares the pin, so the upper buffer half is lost
            top_address_bit <= rate_meter_enable ? 1'b0 : top_address_in;
        end
    end

    // ==================================================================
    // Lock tracking
    typedef enum logic {RESU_HUNT, RESU_LOCKED} resu_lock_t;
    resu_lock_t lock_state;
    logic [1:0] pre_cnt_reg;
    logic [2:0] miss_cnt_reg;
    logic       line_ok;

    assign line_ok = sync_in.line_active && sync_in.rate_in_range;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            lock_state   <= RESU_HUNT;
            pre_cnt_reg  <= 2'h0;
            miss_cnt_reg <= 3'h0;
        end else if (!line_ok) begin
            lock_state   <= RESU_HUNT;
            pre_cnt_reg  <= 2'h0;
            miss_cnt_reg <= 3'h0;
        end else begin
            unique case (lock_state)
                RESU_HUNT: begin
                    miss_cnt_reg <= 3'h0;
                    if (sync_in.block_pre) begin
                        if (pre_cnt_reg == 2'(LOCK_FRAMES)) begin
                            lock_state <= RESU_LOCKED;
                        end
                        pre_cnt_reg <= 2'h0;
                    end else if (sync_in.frame_pre && pre_cnt_reg != 2'(LOCK_FRAMES)) begin
                        pre_cnt_reg <= pre_cnt_reg + 2'h1;
                    end
                end
                RESU_LOCKED: begin
                    if (sync_in.frame_pre || sync_in.block_pre) begin
                        miss_cnt_reg <= 3'h0;
                    end else if (sync_in.frame_slot) begin
                        if (miss_cnt_reg == 3'(LOSS_MISSES - 1)) begin
                            lock_state   <= RESU_HUNT;
                            miss_cnt_reg <= 3'h0;
                        end else begin
                            miss_cnt_reg <= miss_cnt_reg + 3'h1;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            locked <= 1'b0;
        end else begin
            locked <= (lock_state == RESU_LOCKED);
        end
    end

    // ==================================================================
    // Rate meter: one window is 64 frames, a third of a block
    logic        ref_q1;
    logic        ref_q2;
    logic [13:0] ref_cnt_reg;
    logic [5:0]  win_cnt_reg;
    logic [2:0]  rate_code;
    logic [2:0]  rate_next;
    logic        frame_tick;
    logic        meter_run;

    assign frame_tick = sync_in.frame_pre || sync_in.block_pre;
    assign meter_run  = rate_meter_enable && lock_state == RESU_LOCKED;

    always_comb begin
        rate_next = RATE_NONE;
        if (ref_cnt_reg >= R48_N_LO && ref_cnt_reg <= R48_N_HI) begin
            rate_next = RATE_48_N;
        end else if (ref_cnt_reg >= R441_N_LO && ref_cnt_reg <= R441_N_HI) begin
            rate_next = RATE_441_N;
        end else if (ref_cnt_reg >= R44_N_LO && ref_cnt_reg <= R44_N_HI) begin
            rate_next = RATE_44_N;
        end else if (ref_cnt_reg >= R32_N_LO && ref_cnt_reg <= R32_N_HI) begin
            rate_next = RATE_32_N;
        end else if (ref_cnt_reg >= R48_W_LO && ref_cnt_reg <= R48_W_HI) begin
            rate_next = RATE_48_W;
        end else if (ref_cnt_reg >= R441_W_LO && ref_cnt_reg <= R441_W_HI) begin
            rate_next = RATE_441_W;
        end else if (ref_cnt_reg >= R32_W_LO && ref_cnt_reg <= R32_W_HI) begin
            rate_next = RATE_32_W;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ref_q1 <= 1'b0;
            ref_q2 <= 1'b0;
        end else begin
            ref_q1 <= rate_reference_clock;
            ref_q2 <= ref_q1;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ref_cnt_reg <= 14'h0;
            win_cnt_reg <= 6'h0;
            rate_code   <= RATE_NONE;
        end else if (!meter_run) begin
            // Code only means something while locked and enabled
            ref_cnt_reg <= 14'h0;
            win_cnt_reg <= 6'h0;
            rate_code   <= RATE_NONE;
        end else begin
            if (frame_tick && win_cnt_reg == WINDOW_LAST) begin
                rate_code   <= rate_next;
                ref_cnt_reg <= 14'h0;
            end else if (ref_q1 && !ref_q2 && ref_cnt_reg != 14'h3fff) begin
                ref_cnt_reg <= ref_cnt_reg + 14'h1;
            end
            if (frame_tick) begin
                win_cnt_reg <= win_cnt_reg + 6'h1;
            end
        end
    end

    // ==================================================================
    // Line error latches and error pin
    logic [3:0] line_set;
    logic [3:0] line_lat_reg;
    logic [3:0] line_lat_next;
    logic       err_evt;

    assign line_set[BIT_VALIDITY] = line_ev.validity;
    assign line_set[BIT_PARITY]   = line_ev.parity;
    assign line_set[BIT_CODING]   = line_ev.coding;
    assign line_set[BIT_LOCK]     = lock_state != RESU_LOCKED;

    // Set beats the clear so an event in the read cycle survives
    assign line_lat_next = (clr_line ? 4'h0 : line_lat_reg) | line_set;
    assign err_evt       = |({1'b0, line_set} & line_error_enable[4:0]);
    assign line_error_status = {rate_code, 1'b0, line_lat_reg};

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            line_lat_reg <= 4'h0;
        end else begin
            line_lat_reg <= line_lat_next;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            error_pin <= 1'b0;
        end else begin
            error_pin <= |({1'b0, line_lat_next} & line_error_enable[4:0]);
        end
    end

    // ==================================================================
    // First-level flag and interrupt
    logic       err_flag_reg;
    logic [7:0] first_rise;
    logic       fire;

    assign first_status_reg = {4'h0, err_flag_reg, 3'h0};
    assign first_rise       = {4'h0, err_evt && !err_flag_reg, 3'h0};
    assign fire             = |(first_rise & first_level_irq_enable);

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            err_flag_reg <= 1'b0;
        end else if (err_evt) begin
            err_flag_reg <= 1'b1;
        end else if (clr_first) begin
            err_flag_reg <= 1'b0;
        end
    end

    resu_int_pulse u_int_pulse (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .fire    (fire),
        .int_n   (int_n)
    );

    // ==================================================================
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    sequence s_hunt_three;
        lock_state == RESU_HUNT && pre_cnt_reg == 2'(LOCK_FRAMES);
    endsequence

    sequence s_block_seen;
        sync_in.block_pre && line_ok;
    endsequence

    a_lock_gain: assert property (s_hunt_three ##0 s_block_seen |=> ##1 locked)
        else $error("lock not taken after three frames and a block preamble");

    a_enabled_err: assert property (err_evt |=> error_pin)
        else $error("error pin missed an enabled error");

    a_err_masked: assert property (
        (line_error_enable[4:0] == 5'h0) && $stable(line_error_enable) |=> !error_pin)
        else $error("error pin high with all enables clear");

    a_flag_irq: assert property (
        err_evt && !err_flag_reg && first_level_irq_enable[BIT_ERROR_FLAG] && int_n
        |=> !int_n)
        else $error("no interrupt on first error flag");

    a_no_rearm: assert property (err_flag_reg && int_n |=> int_n)
        else $error("error flag interrupted twice without a read");

    a_irq_masked: assert property (
        !first_level_irq_enable[BIT_ERROR_FLAG] && int_n |=> int_n)
        else $error("masked flag fired an interrupt");

    a_int_width: assert property ($fell(int_n) |-> !int_n [*8])
        else $error("interrupt pulse too short");

    a_read_clear: assert property (
        clr_line && line_set == 4'h0 |=> line_lat_reg == 4'h0)
        else $error("line latches not cleared by read");

    a_set_wins: assert property (
        clr_line && line_ev.parity |=> line_lat_reg[BIT_PARITY])
        else $error("parity event lost under clear");

    a_addr_force: assert property (rate_meter_enable |=> !top_address_bit)
        else $error("top address bit not forced low");

    a_rate_idle: assert property (!meter_run |=> rate_code == RATE_NONE)
        else $error("rate code reported while not measuring");

    a_unlock_set: assert property (!line_ok |=> ##1 line_lat_reg[BIT_LOCK])
        else $error("lock latch not set on lost line");
endmodule
